/* File: common/dssa_pkg.sv */
`default_nettype none
package dssa_pkg;

  localparam int unsigned DataWidth  = 64;
  localparam int unsigned FuncWidth  = 6;
  localparam int unsigned CountWidth = 6;

  // Register-format major opcode and function codes
  localparam logic [5:0] OpcRegFormat       = 6'h00;
  localparam logic [5:0] FnArithShiftHigh   = 6'h3F;
  localparam logic [5:0] FnArithShiftVar    = 6'h17;
  localparam logic [5:0] FnLogicShiftLow    = 6'h3A;
  localparam logic [5:0] FnLogicShiftHigh   = 6'h3E;
  localparam logic [5:0] FnLogicShiftVar    = 6'h16;
  localparam logic [5:0] FnTrappingSubtract = 6'h2E;
  localparam logic [5:0] FnModuloSubtract   = 6'h2F;

  // Offset added to the immediate count by the high forms
  localparam logic [5:0] HighShiftBias = 6'h20;

  // Execute latency in cycles
  localparam int unsigned ExecLatency = 1;

  // Reset values
  localparam logic [63:0] ResultReset = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    DSSA_OP_NONE,
    DSSA_OP_SHIFT,
    DSSA_OP_TRAP_SUB,
    DSSA_OP_MOD_SUB,
    DSSA_OP_RESERVED
  } dssa_op_e;

  // Decoded instruction from the pipeline
  typedef struct packed {
    logic        valid;
    logic [5:0]  opcode;
    logic [5:0]  func;
    logic [4:0]  immShiftCount;
    logic [4:0]  destIndex;
    logic [63:0] operandAReg;
    logic [63:0] operandBReg;
  } dssa_req_s;

  // Writeback and exception answer
  typedef struct packed {
    logic        valid;
    logic        writeEnable;
    logic [4:0]  destIndex;
    logic [63:0] result;
    logic        intOverflow;
    logic        reservedInstr;
  } dssa_rsp_s;

endpackage : dssa_pkg
`default_nettype wire

/* File: rtl/dssa_alu.sv */
`default_nettype none
// Notes on behaviour
// - High arithmetic shift: imm plus 32, sign fill
// - Variable arithmetic shift: low six bits, sign fill
// - Low logical shift: imm 0..31, zero fill
// - High logical shift: imm plus 32, zero fill
// - Variable logical shift: low six bits, zero fill
// - Trapping subtract: overflow blocks write, raises trap
// - Modulo subtract writes difference, never traps
// - Neither the subtracts nor the shifts flag reserved instruction; other opcodes and function codes do
module dssa_alu
  import dssa_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire dssa_pkg::dssa_req_s req,
  output logic                     rspValid,
  output logic                     rspWriteEnable,
  output logic [4:0]               rspDestIndex,
  output logic [63:0]              rspResult,
  output logic                     rspIntOverflow,
  output logic                     rspReservedInstr
);
  import dssa_pkg::*;

  typedef struct packed {
    dssa_rsp_s rsp;
  } dssa_state_s;

  dssa_state_s stateQ;
  dssa_state_s stateD;

  dssa_op_e         opKind;
  logic [5:0]       shiftCount;
  logic             shiftArith;
  logic [63:0]      shifted;
  logic [64:0]      wideDiff;
  logic             overflow;

  // Classify a function code under the register-format opcode
  function automatic dssa_op_e classify(input logic [5:0] opc, input logic [5:0] fn);
    if (opc != OpcRegFormat) begin
      return DSSA_OP_RESERVED;
    end
    unique case (fn)
      FnArithShiftHigh, FnArithShiftVar, FnLogicShiftLow,
      FnLogicShiftHigh, FnLogicShiftVar: return DSSA_OP_SHIFT;
      FnTrappingSubtract:                return DSSA_OP_TRAP_SUB;
      FnModuloSubtract:                  return DSSA_OP_MOD_SUB;
      default:                           return DSSA_OP_RESERVED;
    endcase
  endfunction : classify

  // Decode and shift count selection
  always_comb begin
    opKind     = req.valid ? classify(req.opcode, req.func) : DSSA_OP_NONE;
    shiftArith = 1'b0;
    shiftCount = {1'b0, req.immShiftCount};
    unique case (req.func)
      FnArithShiftHigh: begin
        shiftArith = 1'b1;
        shiftCount = HighShiftBias | {1'b0, req.immShiftCount};
      end
      FnArithShiftVar: begin
        shiftArith = 1'b1;
        shiftCount = req.operandAReg[5:0];
      end
      FnLogicShiftHigh: begin
        shiftCount = HighShiftBias | {1'b0, req.immShiftCount};
      end
      FnLogicShiftVar: begin
        shiftCount = req.operandAReg[5:0];
      end
      default: begin
        shiftCount = {1'b0, req.immShiftCount};
      end
    endcase
  end

  dssa_shifter #(
    .Width (DataWidth)
  ) u_shifter (
    .source  (req.operandBReg),
    .count   (shiftCount),
    .arith   (shiftArith),
    .shifted (shifted)
  );

  // Sign-extended 65-bit difference and overflow test
  always_comb begin
    wideDiff = {req.operandAReg[63], req.operandAReg} - {req.operandBReg[63], req.operandBReg};
    overflow = wideDiff[64] != wideDiff[63];
  end

  // Next answer
  always_comb begin
    stateD                   = stateQ;
    stateD.rsp.valid         = req.valid;
    stateD.rsp.destIndex     = req.destIndex;
    stateD.rsp.writeEnable   = 1'b0;
    stateD.rsp.intOverflow   = 1'b0;
    stateD.rsp.reservedInstr = 1'b0;
    unique case (opKind)
      DSSA_OP_SHIFT: begin
        stateD.rsp.result      = shifted;
        stateD.rsp.writeEnable = 1'b1;
      end
      DSSA_OP_TRAP_SUB: begin
        stateD.rsp.result      = wideDiff[63:0];
        stateD.rsp.writeEnable = !overflow;
        stateD.rsp.intOverflow = overflow;
      end
      DSSA_OP_MOD_SUB: begin
        stateD.rsp.result      = wideDiff[63:0];
        stateD.rsp.writeEnable = 1'b1;
      end
      DSSA_OP_RESERVED: begin
        stateD.rsp.reservedInstr = 1'b1;
      end
      DSSA_OP_NONE: begin
        stateD.rsp.valid = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ.rsp <= '{valid: 1'b0, writeEnable: 1'b0, destIndex: 5'h00,
                      result: ResultReset, intOverflow: 1'b0, reservedInstr: 1'b0};
    end else begin
      stateQ <= stateD;
    end
  end

  assign rspValid         = stateQ.rsp.valid;
  assign rspWriteEnable   = stateQ.rsp.writeEnable;
  assign rspDestIndex     = stateQ.rsp.destIndex;
  assign rspResult        = stateQ.rsp.result;
  assign rspIntOverflow   = stateQ.rsp.intOverflow;
  assign rspReservedInstr = stateQ.rsp.reservedInstr;

  // Checks
  function automatic logic isGood(input dssa_req_s r, input logic [5:0] fn);
    return r.valid && r.opcode == OpcRegFormat && r.func == fn;
  endfunction : isGood

  property p_arith_high;
    @(posedge clk) disable iff (rst)
    isGood(req, FnArithShiftHigh) |=> rspWriteEnable &&
      rspResult == 64'($signed($past(req.operandBReg)) >>> (32 + $past(req.immShiftCount)));
  endproperty
  a_arith_high: assert property (p_arith_high) else $error("high arith shift wrong");

  property p_arith_var;
    @(posedge clk) disable iff (rst)
    isGood(req, FnArithShiftVar) |=>
      rspResult == 64'($signed($past(req.operandBReg)) >>> $past(req.operandAReg[5:0]));
  endproperty
  a_arith_var: assert property (p_arith_var) else $error("variable arith shift wrong");

  property p_logic_low;
    @(posedge clk) disable iff (rst)
    isGood(req, FnLogicShiftLow) |=>
      rspResult == ($past(req.operandBReg) >> $past(req.immShiftCount));
  endproperty
  a_logic_low: assert property (p_logic_low) else $error("low logic shift wrong");

  property p_logic_high;
    @(posedge clk) disable iff (rst)
    isGood(req, FnLogicShiftHigh) |=>
      rspResult == ($past(req.operandBReg) >> (32 + $past(req.immShiftCount)));
  endproperty
  a_logic_high: assert property (p_logic_high) else $error("high logic shift wrong");

  property p_logic_var;
    @(posedge clk) disable iff (rst)
    isGood(req, FnLogicShiftVar) |=>
      rspResult == ($past(req.operandBReg) >> $past(req.operandAReg[5:0]));
  endproperty
  a_logic_var: assert property (p_logic_var) else $error("variable logic shift wrong");

  property p_trap_sub;
    @(posedge clk) disable iff (rst)
    isGood(req, FnTrappingSubtract) && overflow |=> rspIntOverflow && !rspWriteEnable;
  endproperty
  a_trap_sub: assert property (p_trap_sub) else $error("overflow not trapped");

  property p_mod_sub;
    @(posedge clk) disable iff (rst)
    isGood(req, FnModuloSubtract) |=> !rspIntOverflow && rspWriteEnable &&
      rspResult == $past(req.operandAReg) - $past(req.operandBReg);
  endproperty
  a_mod_sub: assert property (p_mod_sub) else $error("modulo subtract wrong");

  property p_reserved;
    @(posedge clk) disable iff (rst)
    req.valid && req.opcode != OpcRegFormat |=> rspReservedInstr && !rspWriteEnable;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not flagged");

  property p_latency;
    @(posedge clk) disable iff (rst)
    req.valid |-> ##1 rspValid;
  endproperty
  a_latency: assert property (p_latency) else $error("answer not in one cycle");

  c_overflow: cover property (@(posedge clk) disable iff (rst) rspIntOverflow);
  c_reserved: cover property (@(posedge clk) disable iff (rst) rspReservedInstr);
  c_shift63:  cover property (@(posedge clk) disable iff (rst)
                isGood(req, FnArithShiftVar) && req.operandAReg[5:0] == 6'h3F);
endmodule : dssa_alu
`default_nettype wire

/* File: rtl/dssa_shifter.sv */
`default_nettype none
module dssa_shifter #(
  parameter int unsigned Width = 64
) (
  input  wire logic [Width-1:0] source,
  input  wire logic [5:0]       count,
  input  wire logic             arith,
  output logic      [Width-1:0] shifted
);
  // Sign or zero fill selected by arith
  always_comb begin
    shifted = Width'($signed({arith & source[Width-1], source}) >>> count);
  end
endmodule : dssa_shifter
`default_nettype wire

/* File: testbench/dssa_pipe_model.sv */
`default_nettype none
// Pipeline writeback side: register file and trap counter
module dssa_pipe_model
  import dssa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rspValid,
  input  wire logic        rspWriteEnable,
  input  wire logic        rspIntOverflow,
  input  wire logic [4:0]  rspDestIndex,
  input  wire logic [63:0] rspResult
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] regFile [32];
  int          trapCount;

  // Write back only when enabled, so a trapped result never lands
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        regFile[i] <= 64'h0;
      end
      trapCount <= 0;
    end else if (rspValid) begin
      if (rspWriteEnable) begin
        regFile[rspDestIndex] <= rspResult;
      end
      if (rspIntOverflow) begin
        trapCount <= trapCount + 1;
      end
    end
  end
endmodule : dssa_pipe_model
`default_nettype wire

/* File: testbench/test_doubleword_shift_subtract_alu.sv */
`default_nettype none
module test_doubleword_shift_subtract_alu;
  timeunit 1ns;
  timeprecision 1ps;
  import dssa_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  dssa_req_s   req = '0;
  dssa_req_s   prevReq = '0;
  logic        rspValid, rspWriteEnable, rspIntOverflow, rspReservedInstr;
  logic [4:0]  rspDestIndex;
  logic [63:0] rspResult;
  int          errors = 0;
  int          n_checks = 0;
  logic [5:0]  fns [5] = '{FnArithShiftHigh, FnArithShiftVar, FnLogicShiftLow,
                          FnLogicShiftHigh, FnLogicShiftVar};

  always #25 clk = ~clk;

  dssa_alu u_dut (.clk(clk), .rst(rst), .req(req), .rspValid(rspValid),
    .rspWriteEnable(rspWriteEnable), .rspDestIndex(rspDestIndex), .rspResult(rspResult),
    .rspIntOverflow(rspIntOverflow), .rspReservedInstr(rspReservedInstr));
  dssa_pipe_model u_pipe (.clk(clk), .rst(rst), .rspValid(rspValid),
    .rspWriteEnable(rspWriteEnable), .rspIntOverflow(rspIntOverflow),
    .rspDestIndex(rspDestIndex), .rspResult(rspResult));

  function automatic dssa_req_s mk(logic [5:0] opc, logic [5:0] fn, logic [4:0] imm,
                                   logic [4:0] dst, logic [63:0] a, logic [63:0] b);
    mk = '{1'b1, opc, fn, imm, dst, a, b};
  endfunction : mk

  // Expected answer worked out from the instruction alone
  function automatic dssa_rsp_s ref_rsp(dssa_req_s r);
    dssa_rsp_s   e;
    logic [64:0] t;
    e = '0;
    e.valid = r.valid;
    e.destIndex = r.destIndex;
    e.writeEnable = r.valid;
    t = {r.operandAReg[63], r.operandAReg} - {r.operandBReg[63], r.operandBReg};
    if (r.valid && r.opcode !== OpcRegFormat) begin
      e.writeEnable = 1'b0;
      e.reservedInstr = 1'b1;
    end else if (r.valid) begin
      case (r.func)
        FnArithShiftHigh: e.result = $signed(r.operandBReg) >>> {1'b1, r.immShiftCount};
        FnArithShiftVar:  e.result = $signed(r.operandBReg) >>> r.operandAReg[5:0];
        FnLogicShiftLow:  e.result = r.operandBReg >> {1'b0, r.immShiftCount};
        FnLogicShiftHigh: e.result = r.operandBReg >> {1'b1, r.immShiftCount};
        FnLogicShiftVar:  e.result = r.operandBReg >> r.operandAReg[5:0];
        FnModuloSubtract: e.result = t[63:0];
        FnTrappingSubtract: begin
          e.result = t[63:0];
          e.intOverflow = t[64] ^ t[63];
          e.writeEnable = ~e.intOverflow;
        end
        default: begin
          e.writeEnable = 1'b0;
          e.reservedInstr = 1'b1;
        end
      endcase
    end
    return e;
  endfunction : ref_rsp

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Presents the next request and judges the answer to the previous one
  task automatic step(input dssa_req_s r);
    dssa_rsp_s e;
    e = ref_rsp(prevReq);
    @(posedge clk);
    req <= r;
    prevReq = r;
    #1;
    check("valid", 64'(e.valid), 64'(rspValid));
    check("wen", 64'(e.writeEnable), 64'(rspWriteEnable));
    check("ovf", 64'(e.intOverflow), 64'(rspIntOverflow));
    check("rsv", 64'(e.reservedInstr), 64'(rspReservedInstr));
    if (e.writeEnable) begin
      check("dest", 64'(e.destIndex), 64'(rspDestIndex));
      check("result", e.result, rspResult);
    end
  endtask : step

  // Every shift form, boundary counts, both signs, back to back
  task automatic t_shifts();
    logic [63:0] srcs [2] = '{64'h8123_4567_89AB_CDEF, 64'h7EDC_BA98_7654_3210};
    logic [4:0]  imms [3] = '{5'h00, 5'h1F, 5'h05};
    logic [63:0] cnts [3] = '{64'h0, 64'h3F, 64'hFFFF_FFFF_FFFF_FF45};
    foreach (fns[f]) foreach (srcs[s]) foreach (imms[c]) begin
      step(mk(OpcRegFormat, fns[f], imms[c], 5'(c + 1), cnts[c], srcs[s]));
    end
    step('0);
    $display("test shifts done");
  endtask : t_shifts

  // Overflow corners of both subtracts; trapped write must not land
  task automatic t_subtract();
    logic [63:0] as [4] = '{64'h5, 64'h8000_0000_0000_0000, 64'h7FFF_FFFF_FFFF_FFFF, 64'h0};
    logic [63:0] bs [4] = '{64'h7, 64'h1, 64'hFFFF_FFFF_FFFF_FFFF, 64'h8000_0000_0000_0000};
    foreach (as[i]) begin
      step(mk(OpcRegFormat, FnTrappingSubtract, 5'h1F, 5'h4, as[i], bs[i]));
      step(mk(OpcRegFormat, FnModuloSubtract, 5'h1F, 5'h5, as[i], bs[i]));
    end
    step(mk(OpcRegFormat, FnModuloSubtract, 5'h0, 5'h3, 64'hA, 64'h3));
    step(mk(OpcRegFormat, FnTrappingSubtract, 5'h0, 5'h3, as[1], bs[1]));
    step('0);
    step('0);
    check("kept", 64'h7, u_pipe.regFile[3]);
    check("traps", 64'h4, 64'(u_pipe.trapCount));
    $display("test subtract done");
  endtask : t_subtract

  // Unknown major opcode and function codes
  task automatic t_reserved();
    step(mk(6'h01, FnModuloSubtract, 5'h0, 5'h6, 64'h1, 64'h1));
    step(mk(OpcRegFormat, 6'h01, 5'h0, 5'h6, 64'h1, 64'h1));
    step(mk(OpcRegFormat, 6'h30, 5'h0, 5'h6, 64'h1, 64'h1));
    step('0);
    $display("test reserved done");
  endtask : t_reserved

  // Reset in mid-run drops a pending instruction
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    req <= mk(OpcRegFormat, FnModuloSubtract, 5'h0, 5'h2, 64'h9, 64'h1);
    @(posedge clk);
    #1;
    check("rstvalid", 64'h0, 64'(rspValid));
    // Withdraw the request while reset still stands, so no attempt straddles the release
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    rst <= 1'b0;
    prevReq = '0;
    step('0);
    $display("test reset done");
  endtask : t_reset

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_shifts();
    t_subtract();
    t_reserved();
    t_reset();
    t_shifts();
    final_report();
  end

  // Watchdog at 2000 cycles, well past the expected hundred or so
  initial begin
    #(50 * 2000);
    errors++;
    final_report();
  end
endmodule : test_doubleword_shift_subtract_alu
`default_nettype wire
